// *** tb/rct_timer1_assertions.sv ***
// Checker for the Timer1 register port, count readback and interrupt
`timescale 1ns/100ps
module rct_chk
  import rct_pkg::*;
(
  // Ports of the timer block
  input wire logic clk,
  input wire logic rst_n,
  input wire rct_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic [15:0] timer0_count,
  input wire logic timer1_underflow,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read data only move after a read strobe; readback ties to the last write
  a_rdata_hold: assert property (!$past(bus.rd) |-> $stable(rdata))
    else $error("read data moved");
  a_t0_low: assert property (bus.rd && bus.addr == ADDR_T0_LOW
    |=> rdata == $past(timer0_count[7:0])) else $error("timer0 byte wrong");
  a_ctrl_rsvd: assert property (bus.rd && bus.addr == ADDR_T1_CTRL
    |=> !rdata[6] && !rdata[2]) else $error("reserved bit set");
  a_ctrl_mask: assert property (bus.wr && bus.addr == ADDR_T1_CTRL ##1 !bus.wr
    ##1 bus.rd && bus.addr == ADDR_T1_CTRL
    |=> rdata == ($past(bus.wdata, 3) & CTRL_WRITE_MASK)) else $error("ctrl readback");
  a_reload_lo: assert property (bus.wr && bus.addr == ADDR_T1_RELOAD_LO ##1 !bus.wr
    ##1 bus.rd && bus.addr == ADDR_T1_RELOAD_LO
    |=> rdata == $past(bus.wdata, 3)) else $error("reload readback");
  a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (bus.wr && bus.addr == ADDR_IRQ_MASK && !bus.wdata[0]
    ##1 !bus.wr |=> !irq) else $error("irq while masked");
  a_uf_pulse: assert property (timer1_underflow |=> !timer1_underflow)
    else $error("underflow pulse too long");
endmodule
bind rct_timer1 rct_chk u_chk(.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .timer0_count(timer0_count), .timer1_underflow(timer1_underflow), .irq(irq));

// *** tb/testbench.sv ***
// Self-checking bench for the Timer1 block
`timescale 1ns/100ps
module testbench
  import rct_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0;
  logic irq;
  logic low_frequency_oscillator = 1'b0;
  logic uf;
  logic uf_seen = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [7:0] rdata;
  rct_bus_t bus = '0;
  int n_errors = 0, num_checks = 0;
  // Events in ev: tx end, rx bit, frame start, timer0 and timer2 underflow
  rct_timer1 uut(.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .tx_done(ev[4]),
    .rx_bit(ev[3]), .rx_frame_start(ev[2]), .timer0_count(16'h5aa5), .timer0_underflow(ev[1]),
    .timer2_underflow(ev[0]), .lfo_clk_pin(low_frequency_oscillator), .timer1_underflow(uf), .irq(irq));
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  // Remember that an underflow pulse was seen; it is too short to poll
  always @(posedge clk) if (uf) uf_seen <= 1'b1;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle; read data are judged just after the edge where they stand
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, w, !w};
    @(posedge clk) bus <= '{a, d, 1'b0, 1'b0};
    #1 if (!w) chk($sformatf("reg_%h", a), d, rdata);
  endtask
  // Single-cycle event pulses with a gap so ticks never merge
  task automatic pulse(input logic [4:0] m, input int n);
    repeat (n) begin
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 5'h00;
    end
  endtask
  // Reserved control bits, read-only bytes and an unmapped place
  task automatic s_regs();
    acc(1'b1, ADDR_T1_CTRL, 8'hff);
    acc(1'b0, ADDR_T1_CTRL, 8'hbb);
    acc(1'b0, ADDR_T0_LOW, 8'ha5);
    acc(1'b1, ADDR_T1_COUNT_HI, 8'hff);
    acc(1'b0, ADDR_T1_COUNT_HI, 8'h00);
    acc(1'b0, 8'h00, 8'h00);
  endtask
  // Software start, one-shot and auto-reload counting, underflow interrupt
  task automatic s_count();
    acc(1'b1, ADDR_T1_RELOAD_LO, 8'h03);
    acc(1'b0, ADDR_T1_RELOAD_LO, 8'h03);
    acc(1'b1, ADDR_T1_CTRL, 8'h02);
    acc(1'b1, ADDR_IRQ_MASK, 8'h01);
    acc(1'b1, ADDR_TIMER_CTRL, 8'h20);
    acc(1'b0, ADDR_TIMER_CTRL, 8'h00);
    acc(1'b1, ADDR_TIMER_CTRL, 8'h22);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h03);
    pulse(5'h02, 2);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h01);
    pulse(5'h02, 2);
    acc(1'b0, ADDR_IRQ_STATUS, 8'h01);
    chk("irq", 8'h01, {7'h00, irq});
    chk("underflow", 8'h01, {7'h00, uf_seen});
    pulse(5'h10, 1);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h00);
    acc(1'b1, ADDR_IRQ_MASK, 8'h00);
    acc(1'b1, ADDR_IRQ_STATUS, 8'h01);
    acc(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    acc(1'b1, ADDR_T1_CTRL, 8'h0b);
    acc(1'b1, ADDR_TIMER_CTRL, 8'h22);
    pulse(5'h01, 4);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h03);
    acc(1'b1, ADDR_T1_RELOAD_LO, 8'h07);
    pulse(5'h01, 1);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h02);
  endtask
  // Start at end of transmit, then stop after four received bits
  task automatic s_start();
    acc(1'b1, ADDR_TIMER_CTRL, 8'h02);
    acc(1'b1, ADDR_T1_CTRL, 8'h9a);
    pulse(5'h10, 1);
    pulse(5'h02, 1);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h06);
    pulse(5'h04, 1);
    pulse(5'h08, 4);
    pulse(5'h02, 2);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h06);
  endtask
  // Trim mode: pin edge starts, received bits ignored, next edge stops
  task automatic s_trim();
    acc(1'b1, ADDR_T1_CTRL, 8'ha2);
    @(posedge clk) low_frequency_oscillator <= 1'b1;
    pulse(5'h00, 2);
    pulse(5'h02, 1);
    pulse(5'h04, 1);
    pulse(5'h08, 4);
    pulse(5'h02, 1);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h05);
    @(posedge clk) low_frequency_oscillator <= 1'b0;
    pulse(5'h00, 2);
    @(posedge clk) low_frequency_oscillator <= 1'b1;
    pulse(5'h00, 2);
    pulse(5'h02, 1);
    acc(1'b0, ADDR_T1_COUNT_LO, 8'h05);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_count();
    s_start();
    s_trim();
    end_sim();
  end
endmodule

// *** verilog/rct_pkg.sv ***
// Constants and types for the reload countdown timer one block
// How it works
// - Timer0 count low byte is readable, read-only, dynamic.
// - Stop-on-receive bit stops Timer1 after first four received bits.
// - In trimming modes the stop-on-receive bit is ignored.
// - Start mode 00: no automatic start from any protocol event.
// - Start mode 01: start automatically at end of transmission.
// - Start mode 10: trimming, start/stop on trim clock rising edge, underflow halts without reload.
// - Start mode 11: trimming, start/stop on trim clock rising edge, underflow allowed.
// - Auto reload set: at zero, reload and keep counting, except in start mode 10, which halts holding zero.
// - Auto reload clear: count to zero, then halt holding zero.
// - Every underflow sets the underflow flag.
// - Clock select 00 is 13.56 MHz tick, 01 is 211.875 kHz tick.
// - Clock select 10 uses Timer0 underflow, 11 Timer2 underflow.
// - Every start event loads the counter from the reload bytes.
// - Reload writes do not disturb a running count.
// - Timer1 count high and low bytes are readable, read-only.
// - Software writes change the running flag only when its write enable bit is written one.
package rct_pkg;
  localparam logic [7:0] ADDR_T0_LOW = 8'h13;
  localparam logic [7:0] ADDR_T1_CTRL = 8'h14;
  localparam logic [7:0] ADDR_T1_RELOAD_HI = 8'h15;
  localparam logic [7:0] ADDR_T1_RELOAD_LO = 8'h16;
  localparam logic [7:0] ADDR_T1_COUNT_HI = 8'h17;
  localparam logic [7:0] ADDR_T1_COUNT_LO = 8'h18;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h31;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h32;
  localparam int BIT_STOP_RX = 7;
  localparam int BIT_START_HI = 5;
  localparam int BIT_START_LO = 4;
  localparam int BIT_AUTO_RELOAD = 3;
  localparam int BIT_CLK_HI = 1;
  localparam int BIT_CLK_LO = 0;
  localparam int BIT_RUNNING = 5;
  localparam int BIT_RUN_WE = 1;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hbb;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam int RX_STOP_BITS = 4;
  // Tick rates in kHz and Hz; divider derived from the 125 MHz system clock
  localparam int CLK_KHZ = 125000;
  localparam int FAST_TICK_KHZ = 13560;
  localparam int SLOW_TICK_HZ = 211875;
  localparam int FAST_DIV = CLK_KHZ / FAST_TICK_KHZ;
  localparam int SLOW_DIV = (CLK_KHZ * 1000) / SLOW_TICK_HZ;
  typedef enum logic [1:0] {START_NONE, START_TX_END, START_TRIM, START_TRIM_UF} rct_start_t;
  typedef enum logic [1:0] {CLK_FAST, CLK_SLOW, CLK_T0_UF, CLK_T2_UF} rct_clk_t;
  typedef struct packed {
    logic stop_on_rx;
    rct_start_t start_mode;
    logic auto_reload;
    rct_clk_t clk_sel;
  } rct_ctrl_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rct_bus_t;
endpackage

// *** verilog/rct_timer1.sv ***
// Timer1 countdown timer with register port and underflow interrupt
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module rct_timer1
  import rct_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire rct_bus_t bus,
  output logic [7:0] rdata,
  // Protocol and neighbour timer events, same clock domain
  input wire logic tx_done,
  input wire logic rx_bit,
  input wire logic rx_frame_start,
  input wire logic [15:0] timer0_count,
  input wire logic timer0_underflow,
  input wire logic timer2_underflow,
  // Trimmed oscillator pin, asynchronous
  input wire logic lfo_clk_pin,
  // Status out
  output logic timer1_underflow,
  output logic irq
);
  rct_ctrl_t ctrl_r;
  logic [15:0] reload_r;
  logic [15:0] count_r;
  logic running_r;
  logic underflow_flag_r;
  logic mask_r;
  logic [2:0] rx_cnt_r;
  logic [7:0] fast_div_r;
  logic [15:0] slow_div_r;
  logic fast_tick;
  logic slow_tick;
  logic tick;
  logic [1:0] lfo_sync_r;
  logic lfo_prev_r;
  logic lfo_rise;
  logic trim_mode;
  logic rx_stop;
  logic zero_hit;
  logic start_evt;
  logic sw_run_we;
  logic [7:0] rdata_nxt;

  function automatic logic hit(input rct_bus_t b, input logic [7:0] a);
    return b.wr && b.addr == a;
  endfunction

  // Dividers for the two internal tick rates; approximate since 125 MHz is not a multiple
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_div_r <= 8'h00;
      slow_div_r <= 16'h0000;
    end else begin
      fast_div_r <= fast_tick ? 8'h00 : fast_div_r + 8'h01;
      slow_div_r <= slow_tick ? 16'h0000 : slow_div_r + 16'h0001;
    end
  end
  assign fast_tick = fast_div_r == 8'(FAST_DIV - 1);
  assign slow_tick = slow_div_r == 16'(SLOW_DIV - 1);

  // Tick source mux, cascading from neighbour timers
  always_comb begin
    unique case (ctrl_r.clk_sel)
      CLK_FAST: tick = fast_tick;
      CLK_SLOW: tick = slow_tick;
      CLK_T0_UF: tick = timer0_underflow;
      CLK_T2_UF: tick = timer2_underflow;
    endcase
  end

  // Two-stage synchroniser for the trim oscillator, edge taken after stage two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfo_sync_r <= 2'b00;
      lfo_prev_r <= 1'b0;
    end else begin
      lfo_sync_r <= {lfo_sync_r[0], lfo_clk_pin};
      lfo_prev_r <= lfo_sync_r[1];
    end
  end
  assign lfo_rise = lfo_sync_r[1] && !lfo_prev_r;

  // Count received bits of a frame for the early stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_r <= 3'h0;
    end else if (rx_frame_start) begin
      rx_cnt_r <= 3'h0;
    end else if (rx_bit && rx_cnt_r != 3'(RX_STOP_BITS)) begin
      rx_cnt_r <= rx_cnt_r + 3'h1;
    end
  end

  assign trim_mode = ctrl_r.start_mode == START_TRIM || ctrl_r.start_mode == START_TRIM_UF;
  // Stop when the fourth bit lands; trimming masks the feature
  assign rx_stop = ctrl_r.stop_on_rx && !trim_mode && rx_bit && !rx_frame_start
                   && rx_cnt_r == 3'(RX_STOP_BITS - 1);
  // Automatic start: tx end in mode 01, trim edge when idle in trim modes, none in 00
  assign start_evt = (ctrl_r.start_mode == START_TX_END && tx_done)
                     || (trim_mode && lfo_rise && !running_r);
  assign sw_run_we = hit(bus, ADDR_TIMER_CTRL) && bus.wdata[BIT_RUN_WE];
  assign zero_hit = running_r && tick && count_r == 16'h0000;

  // Control register; reserved bits dropped on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= rct_ctrl_t'(6'h00);
    end else if (hit(bus, ADDR_T1_CTRL)) begin
      ctrl_r <= rct_ctrl_t'({bus.wdata[7], bus.wdata[5:3], bus.wdata[1:0]});
    end
  end

  // Reload bytes only stored; the counter picks them up at a start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_r <= RELOAD_RESET;
    end else begin
      if (hit(bus, ADDR_T1_RELOAD_HI)) begin
        reload_r[15:8] <= bus.wdata;
      end
      if (hit(bus, ADDR_T1_RELOAD_LO)) begin
        reload_r[7:0] <= bus.wdata;
      end
    end
  end

  // Run state: software write wins first, then the trim edge stop, then starts, then the receive and zero stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running_r <= 1'b0;
    end else if (sw_run_we) begin
      running_r <= bus.wdata[BIT_RUNNING];
    end else if (trim_mode && lfo_rise && running_r) begin
      running_r <= 1'b0;
    end else if (start_evt) begin
      running_r <= 1'b1;
    end else if (rx_stop) begin
      running_r <= 1'b0;
    end else if (zero_hit && !(ctrl_r.auto_reload && ctrl_r.start_mode != START_TRIM)) begin
      running_r <= 1'b0;
    end
  end

  // Counter: load on start, decrement per tick, reload at zero when allowed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 16'h0000;
    end else if (start_evt || (sw_run_we && bus.wdata[BIT_RUNNING])) begin
      count_r <= reload_r;
    end else if (zero_hit) begin
      if (ctrl_r.auto_reload && ctrl_r.start_mode != START_TRIM) begin
        count_r <= reload_r;
      end else begin
        count_r <= 16'h0000;
      end
    end else if (running_r && tick && !rx_stop) begin
      count_r <= count_r - 16'h0001;
    end
  end

  // Underflow pulse, sticky flag with write-one-to-clear where set wins, and mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_underflow <= 1'b0;
      underflow_flag_r <= 1'b0;
      mask_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      timer1_underflow <= zero_hit;
      if (zero_hit) begin
        underflow_flag_r <= 1'b1;
      end else if (hit(bus, ADDR_IRQ_STATUS) && bus.wdata[0]) begin
        underflow_flag_r <= 1'b0;
      end
      if (hit(bus, ADDR_IRQ_MASK)) begin
        mask_r <= bus.wdata[0];
      end
      irq <= (underflow_flag_r || zero_hit) && mask_r;
    end
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (bus.addr)
      ADDR_T0_LOW: rdata_nxt = timer0_count[7:0];
      ADDR_T1_CTRL: rdata_nxt = {ctrl_r.stop_on_rx, 1'b0, ctrl_r.start_mode,
                                 ctrl_r.auto_reload, 1'b0, ctrl_r.clk_sel};
      ADDR_T1_RELOAD_HI: rdata_nxt = reload_r[15:8];
      ADDR_T1_RELOAD_LO: rdata_nxt = reload_r[7:0];
      ADDR_T1_COUNT_HI: rdata_nxt = count_r[15:8];
      ADDR_T1_COUNT_LO: rdata_nxt = count_r[7:0];
      ADDR_TIMER_CTRL: rdata_nxt = 8'(running_r) << BIT_RUNNING;
      ADDR_IRQ_STATUS: rdata_nxt = {7'h00, underflow_flag_r};
      ADDR_IRQ_MASK: rdata_nxt = {7'h00, mask_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      rdata <= rdata_nxt;
    end
  end
endmodule
